//--- bench/tb.sv
// Self-checking bench for the OR and move instruction decoder.
// Assumes omid_pkg and omid_decode are compiled before this file.
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic ref_clk_i;
    logic nrst_i;
    logic instr_valid_i;
    logic [13:0] instr_i;
    logic [7:0] file_rdata_i;
    logic [6:0] file_addr_o;
    logic file_we_o;
    logic [7:0] file_wdata_o;
    logic [7:0] accum_o;
    logic zero_o;
    logic done_o;
    logic unsupported_o;
    int failures;
    int comparisons;

    omid_decode omid_decode_i (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .instr_valid_i(instr_valid_i),
        .instr_i(instr_i),
        .file_rdata_i(file_rdata_i),
        .file_addr_o(file_addr_o),
        .file_we_o(file_we_o),
        .file_wdata_o(file_wdata_o),
        .accum_o(accum_o),
        .zero_o(zero_o),
        .done_o(done_o),
        .unsupported_o(unsupported_o)
    );

    // ======================================================
    // Clock and watchdog
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        #200000;
        failures++;
        $display("watchdog expired");
        end_of_test();
    end

    // ======================================================
    // Shared checks
    task automatic chk(input string nm, input logic [7:0] exp,
                       input logic [7:0] got);
        comparisons++;
        if (exp !== got) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One instruction: same-cycle outputs, then registers after its edge
    task automatic run(input logic [13:0] ins, input logic [7:0] rd,
                       input logic we, input logic [7:0] wd,
                       input logic [7:0] acc, input logic z,
                       input logic dn);
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b1;
        instr_i <= ins;
        file_rdata_i <= rd;
        @(negedge ref_clk_i);
        chk("write strobe", {7'h00, we}, {7'h00, file_we_o});
        chk("file address", {1'b0, ins[6:0]}, {1'b0, file_addr_o});
        if (we) begin
            chk("write data", wd, file_wdata_o);
        end
        chk("done", {7'h00, dn}, {7'h00, done_o});
        chk("unsupported", {7'h00, ~dn}, {7'h00, unsupported_o});
        @(posedge ref_clk_i);
        instr_valid_i <= 1'b0;
        #1;
        chk("accumulator", acc, accum_o);
        chk("zero flag", {7'h00, z}, {7'h00, zero_o});
        chk("idle strobe", 8'h00, {7'h00, file_we_o});
        chk("idle done", 8'h00, {6'h00, done_o, unsupported_o});
    endtask

    // ======================================================
    // Scenarios
    task automatic t_or();
        run(14'h3013, 8'h00, 1'b0, 8'h00, 8'h13, 1'b0, 1'b1);
        run(14'h0421, 8'h91, 1'b0, 8'h00, 8'h93, 1'b0, 1'b1);
        run(14'h04a1, 8'h40, 1'b1, 8'hd3, 8'h93, 1'b0, 1'b1);
        run(14'h3000, 8'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b1);
        run(14'h0405, 8'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
        $display("test or done");
    endtask

    task automatic t_move();
        run(14'h08c3, 8'h7e, 1'b1, 8'h7e, 8'h00, 1'b0, 1'b1);
        run(14'h0843, 8'h80, 1'b0, 8'h00, 8'h80, 1'b0, 1'b1);
        run(14'h08ff, 8'h00, 1'b1, 8'h00, 8'h80, 1'b1, 1'b1);
        $display("test move done");
    endtask

    task automatic t_load();
        logic [7:0] lit;
        for (int i = 0; i < 4; i++) begin
            lit = 8'h5a ^ 8'(i);
            run({4'hc, 2'(i), lit}, 8'h00, 1'b0, 8'h00, lit, 1'b1,
                1'b1);
        end
        run(14'h3000, 8'hff, 1'b0, 8'h00, 8'h00, 1'b1, 1'b1);
        run(14'h3359, 8'h00, 1'b0, 8'h00, 8'h59, 1'b1, 1'b1);
        $display("test load done");
    endtask

    task automatic t_store();
        run(14'h00ff, 8'h33, 1'b1, 8'h59, 8'h59, 1'b1, 1'b1);
        run(14'h0080, 8'h00, 1'b1, 8'h59, 8'h59, 1'b1, 1'b1);
        $display("test store done");
    endtask

    task automatic t_nop();
        for (int i = 0; i < 4; i++) begin
            run({7'h00, 2'(i), 5'h00}, 8'hff, 1'b0, 8'h00, 8'h59, 1'b1,
                1'b1);
        end
        run(14'h0001, 8'h00, 1'b0, 8'h00, 8'h59, 1'b1, 1'b0);
        run(14'h3800, 8'h00, 1'b0, 8'h00, 8'h59, 1'b1, 1'b0);
        $display("test nop done");
    endtask

    // ======================================================
    // Verdict
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        failures = 0;
        comparisons = 0;
        nrst_i = 1'b0;
        instr_valid_i = 1'b0;
        instr_i = 14'h0000;
        file_rdata_i = 8'h00;
        repeat (11) @(posedge ref_clk_i);
        #1;
        chk("reset accumulator", 8'h00, accum_o);
        chk("reset zero flag", 8'h00, {7'h00, zero_o});
        @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        t_or();
        t_move();
        t_load();
        t_store();
        t_nop();
        end_of_test();
    end
endmodule

`default_nettype wire

//--- common/omid_defs.svh
// Constants for the OR and move instruction decoder.
// Assumes inclusion by bare name from files under rtl/ and common/.
`ifndef OMID_DEFS_SVH
`define OMID_DEFS_SVH

// ==========================================================
// Instruction field positions
`define OMID_CLS_HI 13
`define OMID_CLS_LO 12
`define OMID_OP_HI 11
`define OMID_OP_LO 8
`define OMID_DEST_BIT 7
`define OMID_FADDR_HI 6
`define OMID_FADDR_LO 0
`define OMID_LIT_HI 7
`define OMID_LIT_LO 0

// ==========================================================
// Opcode codes
`define OMID_CLS_FILE 2'h0
`define OMID_CLS_LIT 2'h3
`define OMID_OP_OR 4'h4
`define OMID_OP_MOVE 4'h8
`define OMID_OP_ZERO 4'h0
`define OMID_LIT_LOAD_TOP 2'h0
`define OMID_NOP_LOW 5'h00

// ==========================================================
// Reset values and timing
`define OMID_ACCUM_RST 8'h00
`define OMID_ZERO_RST 1'h0
`define OMID_CYCLES_PER_INSTR 1

`endif

//--- common/omid_pkg.sv
// Types for the OR and move instruction decoder.
// Assumes no other package.
package omid_pkg;

    // ======================================================
    // Decoded operation, one-hot
    typedef enum logic [5:0] {
        OMID_NONE = 6'h01,
        OMID_OR_ACCUM_WITH_FILE = 6'h02,
        OMID_MOVE_FILE_REGISTER = 6'h04,
        OMID_LOAD_LITERAL_TO_ACCUM = 6'h08,
        OMID_STORE_ACCUM_TO_FILE = 6'h10,
        OMID_NO_OPERATION = 6'h20
    } omid_op_e;

    // ======================================================
    // Instruction word layout
    typedef struct packed {
        logic [1:0] cls;
        logic [3:0] op;
        logic dest;
        logic [6:0] faddr;
    } omid_instr_s;

    // ======================================================
    // File register write request
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } omid_fwr_s;

endpackage

//--- rtl/omid_alu.sv
// Result and zero computation for the decoder.
// Assumes a decoded one-hot operation from omid_decode.
`timescale 1ns/10ps
`default_nettype none

module omid_alu (
    input wire omid_pkg::omid_op_e op_i,
    input wire logic [7:0] accum_i,
    input wire logic [7:0] fdata_i,
    input wire logic [7:0] literal_i,
    output logic [7:0] result_o,
    output logic zero_o
);

    // ======================================================
    // Result select
    always_comb begin
        unique case (op_i)
            omid_pkg::OMID_OR_ACCUM_WITH_FILE: begin
                result_o = accum_i | fdata_i;
            end
            omid_pkg::OMID_MOVE_FILE_REGISTER: begin
                result_o = fdata_i;
            end
            omid_pkg::OMID_LOAD_LITERAL_TO_ACCUM: begin
                result_o = literal_i;
            end
            omid_pkg::OMID_STORE_ACCUM_TO_FILE: begin
                result_o = accum_i;
            end
            omid_pkg::OMID_NO_OPERATION, omid_pkg::OMID_NONE: begin
                result_o = accum_i;
            end
            default: begin
                result_o = accum_i;
            end
        endcase
    end

    assign zero_o = (result_o == 8'h00);

endmodule

`default_nettype wire

//--- rtl/omid_decode.sv
// Decode and execute for OR, move, literal load, store and no-operation.
// Assumes a register file that returns read data in the same cycle.
`timescale 1ns/10ps
`default_nettype none

`include "omid_defs.svh"

module omid_decode (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic instr_valid_i,
    input wire logic [13:0] instr_i,
    input wire logic [7:0] file_rdata_i,
    output logic [6:0] file_addr_o,
    output logic file_we_o,
    output logic [7:0] file_wdata_o,
    output logic [7:0] accum_o,
    output logic zero_o,
    output logic done_o,
    output logic unsupported_o
);

    // ======================================================
    // Decode functions
    function automatic logic omid_is_lit_load(input logic [13:0] w);
        omid_is_lit_load = (w[`OMID_CLS_HI:`OMID_CLS_LO] == `OMID_CLS_LIT)
            && (w[`OMID_OP_HI:`OMID_OP_HI-1] == `OMID_LIT_LOAD_TOP);
    endfunction

    function automatic logic omid_is_nop(input logic [13:0] w);
        omid_is_nop = (w[`OMID_CLS_HI:`OMID_CLS_LO] == `OMID_CLS_FILE)
            && (w[`OMID_OP_HI:`OMID_OP_LO] == `OMID_OP_ZERO)
            && !w[`OMID_DEST_BIT]
            && (w[4:0] == `OMID_NOP_LOW);
    endfunction

    // ======================================================
    // Field split
    omid_pkg::omid_instr_s iw;
    omid_pkg::omid_op_e op;
    omid_pkg::omid_fwr_s fwr;
    logic [7:0] literal;
    logic [7:0] alu_result;
    logic alu_zero;
    logic file_class;
    logic is_or;
    logic is_move;
    logic is_load;
    logic is_store;
    logic is_nop;
    logic sets_zero;
    logic [7:0] accum_reg;
    logic [7:0] accum_next;
    logic zero_reg;
    logic zero_next;

    assign iw = instr_i;
    assign literal = instr_i[`OMID_LIT_HI:`OMID_LIT_LO];
    assign file_class = (iw.cls == `OMID_CLS_FILE);
    assign is_or = file_class && (iw.op == `OMID_OP_OR);
    assign is_move = file_class && (iw.op == `OMID_OP_MOVE);
    assign is_load = omid_is_lit_load(instr_i);
    assign is_store = file_class && (iw.op == `OMID_OP_ZERO)
        && iw.dest;
    assign is_nop = omid_is_nop(instr_i);

    assign op = !instr_valid_i ? omid_pkg::OMID_NONE
        : is_or ? omid_pkg::OMID_OR_ACCUM_WITH_FILE
        : is_move ? omid_pkg::OMID_MOVE_FILE_REGISTER
        : is_load ? omid_pkg::OMID_LOAD_LITERAL_TO_ACCUM
        : is_store ? omid_pkg::OMID_STORE_ACCUM_TO_FILE
        : is_nop ? omid_pkg::OMID_NO_OPERATION
        : omid_pkg::OMID_NONE;

    // ======================================================
    // Datapath
    omid_alu u_alu (
        .op_i(op),
        .accum_i(accum_reg),
        .fdata_i(file_rdata_i),
        .literal_i(literal),
        .result_o(alu_result),
        .zero_o(alu_zero)
    );

    assign sets_zero = (op == omid_pkg::OMID_OR_ACCUM_WITH_FILE)
        || (op == omid_pkg::OMID_MOVE_FILE_REGISTER);

    // ======================================================
    // Next state of accumulator, zero flag and file write
    always_comb begin
        accum_next = accum_reg;
        zero_next = zero_reg;
        fwr.we = 1'b0;
        fwr.addr = iw.faddr;
        fwr.data = alu_result;
        if (sets_zero) begin
            zero_next = alu_zero;
        end
        unique case (op)
            omid_pkg::OMID_OR_ACCUM_WITH_FILE,
            omid_pkg::OMID_MOVE_FILE_REGISTER: begin
                if (iw.dest) begin
                    fwr.we = 1'b1;
                end else begin
                    accum_next = alu_result;
                end
            end
            omid_pkg::OMID_LOAD_LITERAL_TO_ACCUM: begin
                accum_next = alu_result;
            end
            omid_pkg::OMID_STORE_ACCUM_TO_FILE: begin
                fwr.we = 1'b1;
            end
            omid_pkg::OMID_NO_OPERATION, omid_pkg::OMID_NONE: begin
                accum_next = accum_reg;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            accum_reg <= `OMID_ACCUM_RST;
            zero_reg <= `OMID_ZERO_RST;
        end else begin
            accum_reg <= accum_next;
            zero_reg <= zero_next;
        end
    end

    // ======================================================
    // Outputs
    assign file_addr_o = fwr.addr;
    assign file_we_o = fwr.we;
    assign file_wdata_o = fwr.data;
    assign accum_o = accum_reg;
    assign zero_o = zero_reg;
    assign done_o = instr_valid_i && (op != omid_pkg::OMID_NONE);
    assign unsupported_o = instr_valid_i && (op == omid_pkg::OMID_NONE);

    // ======================================================
    // Checks
    sequence omid_or_to_accum;
        instr_valid_i && is_or && !iw.dest;
    endsequence

    sequence omid_move_to_file;
        instr_valid_i && is_move && iw.dest;
    endsequence

    sequence omid_load;
        instr_valid_i && (iw.cls == `OMID_CLS_LIT)
            && (instr_i[11:10] == 2'h0);
    endsequence

    or_result_z_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        omid_or_to_accum |=>
            (accum_o == ($past(accum_o) | $past(file_rdata_i)))
            && (zero_o == (accum_o == 8'h00)))
        else $error("or result or zero flag wrong");

    move_self_z_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        omid_move_to_file |->
            (file_we_o && (file_wdata_o == file_rdata_i))
            ##1 (zero_o == ($past(file_rdata_i) == 8'h00))
            && $stable(accum_o))
        else $error("move file write or zero flag wrong");

    load_keeps_z_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        omid_load |=>
            (accum_o == $past(instr_i[7:0])) && $stable(zero_o))
        else $error("literal load wrong or zero flag moved");

    load_dontcare_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        omid_load |-> done_o && !file_we_o)
        else $error("literal load not decoded for some dont care bits");

    store_accum_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (instr_valid_i && is_store) |->
            file_we_o && (file_wdata_o == accum_o)
            && (file_addr_o == instr_i[6:0])
            ##1 $stable(zero_o) && $stable(accum_o))
        else $error("store accumulator wrong");

    dest_select_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (instr_valid_i && (is_or || is_move)) |->
            (file_we_o == iw.dest))
        else $error("destination select wrong");

    nop_idle_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        (instr_valid_i && is_nop) |-> !file_we_o && done_o
            ##1 $stable(accum_o) && $stable(zero_o))
        else $error("no operation changed state");

    zero_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        !(instr_valid_i && file_class
            && ((iw.op == `OMID_OP_OR) || (iw.op == `OMID_OP_MOVE)))
            |=> $stable(zero_o))
        else $error("zero flag moved without an or or move");

    refused_idle_a: assert property (
        @(posedge ref_clk_i) disable iff (!nrst_i)
        unsupported_o |-> !file_we_o && !done_o
            ##1 $stable(accum_o) && $stable(zero_o))
        else $error("refused instruction changed state");

endmodule

`default_nettype wire
